// ==== hdl/mailbox_pkg.sv ====
// What this block does
// - Port B read with its mailbox select high reads a mailbox, not the FIFO.
// - Port B output shows mail_one_reg when select high, FIFO output register otherwise.
// - Port C write with its mailbox select high goes into mail_two_reg.
// - Port A clock edge storing into mail_one_reg drives its full flag low.
// - Writes to mail_one_reg are ignored while its full flag is low.
// - Port B mailbox read on port B clock edge returns mail_one flag high.
// - Master or partial reset of the A-to-B FIFO leaves mail_one flag high.
// - Port C clock edge storing into mail_two_reg drives its full flag low.
// - Writes to mail_two_reg are blocked while its full flag is low.
// - Port A mailbox read on port A clock edge returns mail_two flag high.
// - Master or partial reset of the C-to-A FIFO sets mail_two flag high.
// - Master reset one low zeroes both A-to-B pointers and port B output register.
// - Master reset one rising edge latches flag method and default offset select.
// - Same rising edge latches bus width and byte order for ports B and C.
// - Port A mailbox select routes writes to mail_one_reg, reads from mail_two_reg.
`default_nettype none
package mailbox_pkg;
  localparam int MAIL_W = 18;
  localparam int PTR_W  = 11;
  localparam int EV_W   = 6;
  localparam int CFG_W  = 6;
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_MASK     = 8'h04;
  localparam logic [7:0] OFS_CONFIG   = 8'h08;
  localparam logic [7:0] OFS_FLAGS    = 8'h0c;
  localparam logic [7:0] OFS_MAIL_ONE = 8'h10;
  localparam logic [7:0] OFS_MAIL_TWO = 8'h14;
  localparam logic [5:0] MASK_RESET   = 6'h00;
  localparam logic [5:0] STATUS_RESET = 6'h00;
  localparam logic [5:0] CFG_RESET    = 6'h00;
  // Event bits in status and mask
  localparam int EV_ONE_WR    = 0;
  localparam int EV_ONE_RD    = 1;
  localparam int EV_TWO_WR    = 2;
  localparam int EV_TWO_RD    = 3;
  localparam int EV_RST_SHORT = 4;
  localparam int EV_RST_SEL   = 5;
  // Config fields: method, offset select (3), bus size, byte order
  localparam int CFG_METHOD = 0;
  localparam int CFG_OFS    = 1;
  localparam int CFG_SIZE   = 4;
  localparam int CFG_ENDIAN = 5;
  // Control pin positions in the synchronised vector
  localparam int PIN_PORT_A_CLOCK  = 0;
  localparam int PIN_PORT_B_CLOCK  = 1;
  localparam int PIN_PORT_C_CLOCK  = 2;
  localparam int PIN_MASTER_RESET_ONE_N  = 3;
  localparam int PIN_MASTER_RESET_TWO_N  = 4;
  localparam int PIN_PRS1  = 5;
  localparam int PIN_PRS2  = 6;
  localparam int PIN_MBA   = 7;
  localparam int PIN_A_WR  = 8;
  localparam int PIN_A_RD  = 9;
  localparam int PIN_MBB   = 10;
  localparam int PIN_B_RD  = 11;
  localparam int PIN_MBC   = 12;
  localparam int PIN_C_WR  = 13;
  localparam int PIN_CTL_W = 14;
  localparam logic [2:0] RESET_EDGES_MIN = 3'h4;
endpackage : mailbox_pkg
`default_nettype wire

// ==== hdl/mailbox_bypass.sv ====
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`default_nettype none
module mailbox_bypass #(
  parameter int MAIL_W = mailbox_pkg::MAIL_W,
  parameter int PTR_W  = mailbox_pkg::PTR_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              port_a_clock_i,
  input  wire logic              port_b_clock_i,
  input  wire logic              port_c_clock_i,
  input  wire logic              master_reset_one_n_i,
  input  wire logic              master_reset_two_n_i,
  input  wire logic              partial_reset_one_n_i,
  input  wire logic              partial_reset_two_n_i,
  input  wire logic              port_a_mail_select_i,
  input  wire logic              port_a_write_i,
  input  wire logic              port_a_read_i,
  input  wire logic [MAIL_W-1:0] port_a_data_i,
  output logic      [MAIL_W-1:0] port_a_data_o,
  input  wire logic [MAIL_W-1:0] fifo_c_to_a_data_i,
  input  wire logic              port_b_mail_select_i,
  input  wire logic              port_b_read_i,
  input  wire logic [MAIL_W-1:0] fifo_a_to_b_data_i,
  output logic      [MAIL_W-1:0] transmit_port_data_o,
  input  wire logic              port_c_mail_select_i,
  input  wire logic              port_c_write_i,
  input  wire logic [MAIL_W-1:0] port_c_data_i,
  input  wire logic [5:0]        config_pins_i,
  output logic      [5:0]        config_o,
  output logic                   mail_one_full_n_o,
  output logic                   mail_two_full_n_o,
  output logic      [PTR_W-1:0]  fifo_a_to_b_wr_ptr_o,
  output logic      [PTR_W-1:0]  fifo_a_to_b_rd_ptr_o,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_cyc_i,
  output logic                   wb_ack_o,
  output logic                   irq_o
);
  localparam int CTL_W  = mailbox_pkg::PIN_CTL_W;
  localparam int CFG_W  = mailbox_pkg::CFG_W;
  localparam int EV_W   = mailbox_pkg::EV_W;
  localparam int D_A    = CTL_W + CFG_W;
  localparam int D_C    = D_A + MAIL_W;
  localparam int D_FB   = D_C + MAIL_W;
  localparam int D_FA   = D_FB + MAIL_W;
  localparam int SYNC_W = D_FA + MAIL_W;
  // Resets idle high (pins 3 to 6), so no false edge follows rst_i
  localparam logic [SYNC_W-1:0] SYNC_IDLE =
      SYNC_W'(4'hf) << mailbox_pkg::PIN_MASTER_RESET_ONE_N;
  // All pins cross into clk_i; port clocks are sampled, not used as clocks
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_s1_r;
  logic [SYNC_W-1:0] sync_s2_r;
  logic [SYNC_W-1:0] sync_s3_r;

  assign sync_raw = {fifo_c_to_a_data_i, fifo_a_to_b_data_i, port_c_data_i,
                     port_a_data_i, config_pins_i,
                     port_c_write_i, port_c_mail_select_i,
                     port_b_read_i, port_b_mail_select_i,
                     port_a_read_i, port_a_write_i, port_a_mail_select_i,
                     partial_reset_two_n_i, partial_reset_one_n_i,
                     master_reset_two_n_i, master_reset_one_n_i,
                     port_c_clock_i, port_b_clock_i, port_a_clock_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_s1_r <= SYNC_IDLE;
      sync_s2_r <= SYNC_IDLE;
      sync_s3_r <= SYNC_IDLE;
    end else begin
      sync_s1_r <= sync_raw;
      sync_s2_r <= sync_s1_r;
      sync_s3_r <= sync_s2_r;
    end
  end

  // Third stage holds the level just before a port clock edge, so data
  // and selects are taken as the far side set them up for that edge
  logic              a_rise;
  logic              b_rise;
  logic              c_rise;
  logic              master_reset_one_n_rise;
  logic              master_reset_one_n_low;
  logic [CTL_W-1:0]  ctl;
  logic [CFG_W-1:0]  cfg_pin;
  logic [MAIL_W-1:0] a_data;
  logic [MAIL_W-1:0] c_data;
  logic [MAIL_W-1:0] fb_data;
  logic [MAIL_W-1:0] fa_data;
  assign ctl     = sync_s3_r[CTL_W-1:0];
  assign cfg_pin = sync_s3_r[D_A-1:CTL_W];
  assign a_data  = sync_s3_r[D_C-1:D_A];
  assign c_data  = sync_s3_r[D_FB-1:D_C];
  assign fb_data = sync_s3_r[D_FA-1:D_FB];
  assign fa_data = sync_s3_r[SYNC_W-1:D_FA];
  assign a_rise  = sync_s2_r[mailbox_pkg::PIN_PORT_A_CLOCK]
                   & ~sync_s3_r[mailbox_pkg::PIN_PORT_A_CLOCK];
  assign b_rise  = sync_s2_r[mailbox_pkg::PIN_PORT_B_CLOCK]
                   & ~sync_s3_r[mailbox_pkg::PIN_PORT_B_CLOCK];
  assign c_rise  = sync_s2_r[mailbox_pkg::PIN_PORT_C_CLOCK]
                   & ~sync_s3_r[mailbox_pkg::PIN_PORT_C_CLOCK];
  assign master_reset_one_n_rise = sync_s2_r[mailbox_pkg::PIN_MASTER_RESET_ONE_N]
                     & ~sync_s3_r[mailbox_pkg::PIN_MASTER_RESET_ONE_N];
  assign master_reset_one_n_low  = ~ctl[mailbox_pkg::PIN_MASTER_RESET_ONE_N];
  logic              fifo_a_to_b_clr;
  logic              fifo_c_to_a_clr;
  logic              one_wr;
  logic              one_rd;
  logic              two_wr;
  logic              two_rd;
  logic              fifo_a_to_b_wr;
  logic              fifo_a_to_b_rd;
  logic [EV_W-1:0]   ev;
  logic [MAIL_W-1:0] mail_one_r, mail_one_nxt;
  logic [MAIL_W-1:0] mail_two_r, mail_two_nxt;
  logic              mail_one_full_n_r, mail_one_full_n_nxt;
  logic              mail_two_full_n_r, mail_two_full_n_nxt;
  logic [PTR_W-1:0]  wr_ptr_r, wr_ptr_nxt;
  logic [PTR_W-1:0]  rd_ptr_r, rd_ptr_nxt;
  logic [MAIL_W-1:0] b_out_r, b_out_nxt;
  logic [MAIL_W-1:0] tx_r, tx_nxt;
  logic [MAIL_W-1:0] a_out_r, a_out_nxt;
  logic [CFG_W-1:0]  cfg_r, cfg_nxt;
  logic [2:0]        cnt_a_r, cnt_a_nxt;
  logic [2:0]        cnt_b_r, cnt_b_nxt;
  always_comb begin
    fifo_a_to_b_clr = master_reset_one_n_low | ~ctl[mailbox_pkg::PIN_PRS1];
    fifo_c_to_a_clr = ~ctl[mailbox_pkg::PIN_MASTER_RESET_TWO_N] | ~ctl[mailbox_pkg::PIN_PRS2];
    one_wr = a_rise & ctl[mailbox_pkg::PIN_MBA] & ctl[mailbox_pkg::PIN_A_WR]
             & mail_one_full_n_r & ~fifo_a_to_b_clr;
    one_rd = b_rise & ctl[mailbox_pkg::PIN_B_RD]
             & ctl[mailbox_pkg::PIN_MBB];
    two_wr = c_rise & ctl[mailbox_pkg::PIN_MBC] & ctl[mailbox_pkg::PIN_C_WR]
             & mail_two_full_n_r & ~fifo_c_to_a_clr;
    two_rd = a_rise & ctl[mailbox_pkg::PIN_A_RD]
             & ctl[mailbox_pkg::PIN_MBA];
    fifo_a_to_b_wr = a_rise & ~ctl[mailbox_pkg::PIN_MBA]
               & ctl[mailbox_pkg::PIN_A_WR];
    fifo_a_to_b_rd = b_rise & ~ctl[mailbox_pkg::PIN_MBB]
               & ctl[mailbox_pkg::PIN_B_RD];
    mail_one_nxt = one_wr ? a_data : mail_one_r;
    mail_two_nxt = two_wr ? c_data : mail_two_r;
    // A write in the same edge as a read leaves new mail pending
    mail_one_full_n_nxt = mail_one_full_n_r;
    if (one_rd)
      mail_one_full_n_nxt = 1'b1;
    if (one_wr)
      mail_one_full_n_nxt = 1'b0;
    if (fifo_a_to_b_clr)
      mail_one_full_n_nxt = 1'b1;
    mail_two_full_n_nxt = mail_two_full_n_r;
    if (two_rd)
      mail_two_full_n_nxt = 1'b1;
    if (two_wr)
      mail_two_full_n_nxt = 1'b0;
    if (fifo_c_to_a_clr)
      mail_two_full_n_nxt = 1'b1;
    wr_ptr_nxt = fifo_a_to_b_wr ? wr_ptr_r + PTR_W'(1) : wr_ptr_r;
    rd_ptr_nxt = fifo_a_to_b_rd ? rd_ptr_r + PTR_W'(1) : rd_ptr_r;
    b_out_nxt  = fifo_a_to_b_rd ? fb_data : b_out_r;
    if (fifo_a_to_b_clr) begin
      wr_ptr_nxt = '0;
      rd_ptr_nxt = '0;
      b_out_nxt  = '0;
    end
    tx_nxt = ctl[mailbox_pkg::PIN_MBB] ? mail_one_r : b_out_r;
    a_out_nxt = ctl[mailbox_pkg::PIN_MBA] ? mail_two_r : fa_data;
    cfg_nxt = master_reset_one_n_rise ? cfg_pin : cfg_r;
    // Edge counters only run while master reset one is held
    cnt_a_nxt = '0;
    cnt_b_nxt = '0;
    if (master_reset_one_n_low) begin
      cnt_a_nxt = cnt_a_r;
      cnt_b_nxt = cnt_b_r;
      if (a_rise && cnt_a_r < mailbox_pkg::RESET_EDGES_MIN)
        cnt_a_nxt = cnt_a_r + 3'h1;
      if (b_rise && cnt_b_r < mailbox_pkg::RESET_EDGES_MIN)
        cnt_b_nxt = cnt_b_r + 3'h1;
    end
    ev = '0;
    ev[mailbox_pkg::EV_ONE_WR] = one_wr;
    ev[mailbox_pkg::EV_ONE_RD] = one_rd & ~mail_one_full_n_r;
    ev[mailbox_pkg::EV_TWO_WR] = two_wr;
    ev[mailbox_pkg::EV_TWO_RD] = two_rd & ~mail_two_full_n_r;
    ev[mailbox_pkg::EV_RST_SHORT] = master_reset_one_n_rise
        & ((cnt_a_r < mailbox_pkg::RESET_EDGES_MIN)
        | (cnt_b_r < mailbox_pkg::RESET_EDGES_MIN));
    ev[mailbox_pkg::EV_RST_SEL] = master_reset_one_n_low
        & ~ctl[mailbox_pkg::PIN_MBC];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mail_one_r        <= '0;
      mail_two_r        <= '0;
      mail_one_full_n_r <= 1'b1;
      mail_two_full_n_r <= 1'b1;
      wr_ptr_r          <= '0;
      rd_ptr_r          <= '0;
      b_out_r           <= '0;
      tx_r              <= '0;
      a_out_r           <= '0;
      cfg_r             <= mailbox_pkg::CFG_RESET;
      cnt_a_r           <= '0;
      cnt_b_r           <= '0;
    end else begin
      mail_one_r        <= mail_one_nxt;
      mail_two_r        <= mail_two_nxt;
      mail_one_full_n_r <= mail_one_full_n_nxt;
      mail_two_full_n_r <= mail_two_full_n_nxt;
      wr_ptr_r          <= wr_ptr_nxt;
      rd_ptr_r          <= rd_ptr_nxt;
      b_out_r           <= b_out_nxt;
      tx_r              <= tx_nxt;
      a_out_r           <= a_out_nxt;
      cfg_r             <= cfg_nxt;
      cnt_a_r           <= cnt_a_nxt;
      cnt_b_r           <= cnt_b_nxt;
    end
  end

  assign mail_one_full_n_o    = mail_one_full_n_r;
  assign mail_two_full_n_o    = mail_two_full_n_r;
  assign transmit_port_data_o = tx_r;
  assign port_a_data_o        = a_out_r;
  assign config_o             = cfg_r;
  assign fifo_a_to_b_wr_ptr_o = wr_ptr_r;
  assign fifo_a_to_b_rd_ptr_o = rd_ptr_r;

  // Wishbone slave: ack one cycle after request, write lands on ack edge
  logic            wb_req;
  logic            wb_wr;
  logic            ack_r, ack_nxt;
  logic [31:0]     rdat_r, rdat_nxt;
  logic [EV_W-1:0] status_r, status_nxt;
  logic [EV_W-1:0] mask_r, mask_nxt;
  logic [EV_W-1:0] clr;

  always_comb begin
    wb_req  = wb_cyc_i & wb_stb_i;
    wb_wr   = wb_req & ack_r & wb_we_i & wb_sel_i[0];
    ack_nxt = wb_req & ~ack_r;
    clr     = '0;
    if (wb_wr && wb_adr_i == mailbox_pkg::OFS_STATUS)
      clr = wb_dat_i[EV_W-1:0];
    // Set beats clear so no event is lost
    status_nxt = (status_r & ~clr) | ev;
    mask_nxt   = mask_r;
    if (wb_wr && wb_adr_i == mailbox_pkg::OFS_MASK)
      mask_nxt = wb_dat_i[EV_W-1:0];
    rdat_nxt = rdat_r;
    if (wb_req && !ack_r) begin
      rdat_nxt = '0;
      case (wb_adr_i)
        mailbox_pkg::OFS_STATUS:   rdat_nxt[EV_W-1:0]   = status_r;
        mailbox_pkg::OFS_MASK:     rdat_nxt[EV_W-1:0]   = mask_r;
        mailbox_pkg::OFS_CONFIG:   rdat_nxt[CFG_W-1:0]  = cfg_r;
        mailbox_pkg::OFS_FLAGS:
          rdat_nxt[2*PTR_W+1:0] = {rd_ptr_r, wr_ptr_r,
                                   mail_two_full_n_r, mail_one_full_n_r};
        mailbox_pkg::OFS_MAIL_ONE: rdat_nxt[MAIL_W-1:0] = mail_one_r;
        mailbox_pkg::OFS_MAIL_TWO: rdat_nxt[MAIL_W-1:0] = mail_two_r;
        default:                   rdat_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      rdat_r   <= '0;
      status_r <= mailbox_pkg::STATUS_RESET;
      mask_r   <= mailbox_pkg::MASK_RESET;
    end else begin
      ack_r    <= ack_nxt;
      rdat_r   <= rdat_nxt;
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign irq_o    = |(status_r & mask_r);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  tx_mux_a: assert property (1'b1 |=> transmit_port_data_o ==
      ($past(ctl[mailbox_pkg::PIN_MBB]) ? $past(mail_one_r)
                                        : $past(b_out_r)))
    else $error("port B output does not follow mailbox select");
  b_fifo_skip_a: assert property (one_rd && !fifo_a_to_b_clr
      |=> $stable(rd_ptr_r) && $stable(b_out_r))
    else $error("mailbox read on port B touched the FIFO");
  mail_two_route_a: assert property (two_wr
      |=> mail_two_r == $past(c_data) && !mail_two_full_n_o)
    else $error("port C mailbox write not stored");
  one_store_a: assert property (one_wr
      |=> !mail_one_full_n_o && mail_one_r == $past(a_data))
    else $error("port A mailbox write did not set flag low");
  one_block_a: assert property (!mail_one_full_n_o
      |=> $stable(mail_one_r))
    else $error("mail one changed while full");
  one_free_a: assert property (one_rd && !one_wr
      |=> mail_one_full_n_o)
    else $error("port B mailbox read did not free mail one");
  one_reset_a: assert property (fifo_a_to_b_clr |=> mail_one_full_n_o)
    else $error("mail one flag low after reset");
  two_block_a: assert property (!mail_two_full_n_o
      |=> $stable(mail_two_r))
    else $error("mail two changed while full");
  two_free_a: assert property (two_rd && !two_wr && !fifo_c_to_a_clr
      |=> mail_two_full_n_o ##1 mail_two_full_n_o || $past(two_wr))
    else $error("port A mailbox read did not free mail two");
  two_reset_a: assert property (fifo_c_to_a_clr |=> mail_two_full_n_o)
    else $error("mail two flag low after reset");
  ptr_clear_a: assert property (master_reset_one_n_low
      |=> wr_ptr_r == '0 && rd_ptr_r == '0 && b_out_r == '0)
    else $error("master reset did not clear pointers");
  cfg_latch_a: assert property (master_reset_one_n_rise
      |=> config_o == $past(cfg_pin) ##1 $stable(config_o))
    else $error("config not latched at reset release");
  short_reset_a: assert property (master_reset_one_n_rise
      && cnt_a_r < mailbox_pkg::RESET_EDGES_MIN
      |=> status_r[mailbox_pkg::EV_RST_SHORT])
    else $error("short reset not flagged");
endmodule : mailbox_bypass
`default_nettype wire

// ==== testbench/port_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module port_partner (
  input  wire logic        clk_i,
  output logic             port_a_clock_o,
  output logic             port_b_clock_o,
  output logic             port_c_clock_o,
  output logic             master_reset_one_n_o,
  output logic             master_reset_two_n_o,
  output logic             partial_reset_one_n_o,
  output logic             partial_reset_two_n_o,
  output logic             a_sel_o,
  output logic             a_wr_o,
  output logic             a_rd_o,
  output logic      [17:0] a_data_o,
  output logic             b_sel_o,
  output logic             b_rd_o,
  output logic             c_sel_o,
  output logic             c_wr_o,
  output logic      [17:0] c_data_o
);
  initial begin
    {port_a_clock_o, port_b_clock_o, port_c_clock_o} = 3'h0;
    {master_reset_one_n_o, master_reset_two_n_o} = 2'h3;
    {partial_reset_one_n_o, partial_reset_two_n_o} = 2'h3;
    {a_sel_o, a_wr_o, a_rd_o, b_sel_o, b_rd_o, c_sel_o, c_wr_o} = 7'h0;
    a_data_o = 18'h00000;
    c_data_o = 18'h3ffff;
  end
  // Free-running 80 ns port clocks, B and C offset 13 and 27 ns from A, none toggling on a clk_i rise
  initial forever #40 port_a_clock_o = ~port_a_clock_o;
  initial begin
    #13;
    forever #40 port_b_clock_o = ~port_b_clock_o;
  end
  initial begin
    #27;
    forever #40 port_c_clock_o = ~port_c_clock_o;
  end
  // Change pins on the first clk_i rise after a port clock fall, so they are stable well around the rise
  task automatic next_slot(input int p);
    if (p == 0) @(negedge port_a_clock_o);
    else if (p == 1) @(negedge port_b_clock_o);
    else @(negedge port_c_clock_o);
    @(posedge clk_i);
  endtask : next_slot
  task automatic write_a(input logic sel, input logic [17:0] d);
    next_slot(0);
    a_sel_o  <= sel;
    a_wr_o   <= 1'b1;
    a_data_o <= d;
    next_slot(0);
    a_wr_o   <= 1'b0;
    a_data_o <= ~d;
  endtask : write_a
  task automatic read_a(input logic sel);
    next_slot(0);
    a_sel_o <= sel;
    a_rd_o  <= 1'b1;
    next_slot(0);
    a_rd_o  <= 1'b0;
  endtask : read_a
  task automatic read_b(input logic sel);
    next_slot(1);
    b_sel_o <= sel;
    b_rd_o  <= 1'b1;
    next_slot(1);
    b_rd_o  <= 1'b0;
  endtask : read_b
  task automatic write_c(input logic sel, input logic [17:0] d);
    next_slot(2);
    c_sel_o  <= sel;
    c_wr_o   <= 1'b1;
    c_data_o <= d;
    next_slot(2);
    c_wr_o   <= 1'b0;
    c_data_o <= ~d;
  endtask : write_c
  task automatic master_reset();
    next_slot(0);
    c_sel_o              <= 1'b1;
    master_reset_one_n_o <= 1'b0;
    master_reset_two_n_o <= 1'b0;
    // Six A periods give at least four A, B and C rises
    repeat (6) @(posedge port_a_clock_o);
    @(posedge clk_i);
    master_reset_one_n_o <= 1'b1;
    master_reset_two_n_o <= 1'b1;
  endtask : master_reset
  task automatic partial_reset(input logic two);
    next_slot(0);
    if (two) partial_reset_two_n_o <= 1'b0;
    else partial_reset_one_n_o <= 1'b0;
    next_slot(0);
    partial_reset_one_n_o <= 1'b1;
    partial_reset_two_n_o <= 1'b1;
  endtask : partial_reset
endmodule : port_partner
`default_nettype wire

// ==== testbench/mailbox_bypass_and_master_reset_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module mailbox_bypass_and_master_reset_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        pa_clk, pb_clk, pc_clk, mr1_n, mr2_n, pr1_n, pr2_n;
  logic        a_sel, a_wr, a_rd, b_sel, b_rd, c_sel, c_wr;
  logic [17:0] a_din, a_dout, c_din, ca_data, ab_data, tx_data;
  logic [5:0]  cfg_pins, cfg_out;
  logic        full_one_n, full_two_n, irq;
  logic [10:0] wr_ptr, rd_ptr;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o;
  logic [3:0]  wb_sel_i, wr_sel;
  int          errors = 0, tests_run = 0, cycles = 0;
  localparam int TIMEOUT = 30000;

  always #5 clk_i = ~clk_i;

  port_partner pp (.clk_i(clk_i), .port_a_clock_o(pa_clk),
    .port_b_clock_o(pb_clk), .port_c_clock_o(pc_clk),
    .master_reset_one_n_o(mr1_n), .master_reset_two_n_o(mr2_n),
    .partial_reset_one_n_o(pr1_n), .partial_reset_two_n_o(pr2_n),
    .a_sel_o(a_sel), .a_wr_o(a_wr), .a_rd_o(a_rd), .a_data_o(a_din),
    .b_sel_o(b_sel), .b_rd_o(b_rd), .c_sel_o(c_sel), .c_wr_o(c_wr),
    .c_data_o(c_din));

  mailbox_bypass uut (.clk_i(clk_i), .rst_i(rst_i),
    .port_a_clock_i(pa_clk), .port_b_clock_i(pb_clk),
    .port_c_clock_i(pc_clk), .master_reset_one_n_i(mr1_n),
    .master_reset_two_n_i(mr2_n), .partial_reset_one_n_i(pr1_n),
    .partial_reset_two_n_i(pr2_n), .port_a_mail_select_i(a_sel),
    .port_a_write_i(a_wr), .port_a_read_i(a_rd), .port_a_data_i(a_din),
    .port_a_data_o(a_dout), .fifo_c_to_a_data_i(ca_data),
    .port_b_mail_select_i(b_sel), .port_b_read_i(b_rd),
    .fifo_a_to_b_data_i(ab_data), .transmit_port_data_o(tx_data),
    .port_c_mail_select_i(c_sel), .port_c_write_i(c_wr),
    .port_c_data_i(c_din), .config_pins_i(cfg_pins), .config_o(cfg_out),
    .mail_one_full_n_o(full_one_n), .mail_two_full_n_o(full_two_n),
    .fifo_a_to_b_wr_ptr_o(wr_ptr), .fifo_a_to_b_rd_ptr_o(rd_ptr),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i),
    .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .irq_o(irq));

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Flags settle within a few cycles of the detected port edge
  task automatic settle();
    repeat (6) @(posedge clk_i);
  endtask : settle

  task automatic wb_xfer(input logic we, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= we ? wr_sel : 4'($urandom);
    // No answer time assumed; only the bench timeout ends this wait
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer

  task automatic do_master_reset();
    logic [5:0] cfg;
    logic [31:0] q;
    cfg = 6'($urandom);
    cfg_pins <= cfg;
    pp.master_reset();
    @(posedge clk_i);
    cfg_pins <= ~cfg;
    settle();
    check(cfg_out, cfg);
    check({rd_ptr, wr_ptr}, 32'h0);
    check(tx_data, 32'h0);
    check(full_one_n, 1'b1);
    check(full_two_n, 1'b1);
    wb_xfer(1'b0, mailbox_pkg::OFS_FLAGS, 32'h0, q);
    check(q, 32'h3);
  endtask : do_master_reset

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    logic [17:0] d1, d2, f;
    logic [31:0] q;
    int seed_word;
    cfg_pins <= 6'h00;
    ca_data  <= 18'h0;
    ab_data  <= 18'h0;
    wb_adr_i <= 8'h00;
    wb_dat_i <= 32'h0;
    wb_sel_i <= 4'h0;
    {wb_we_i, wb_stb_i, wb_cyc_i} <= 3'h0;
    wr_sel   = 4'hf;
    seed_word = $urandom(32'hb9b65b9d);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({full_one_n, full_two_n}, 2'h3);
    do_master_reset();
    wb_xfer(1'b0, mailbox_pkg::OFS_MASK, 32'h0, q);
    check(q, 32'(mailbox_pkg::MASK_RESET));
    wb_xfer(1'b1, mailbox_pkg::OFS_MASK, 32'h1 << mailbox_pkg::EV_ONE_WR, q);
    // Write without byte lane 0 must be ignored
    wr_sel = 4'he;
    wb_xfer(1'b1, mailbox_pkg::OFS_MASK, 32'h3f, q);
    wr_sel = 4'hf;
    wb_xfer(1'b0, mailbox_pkg::OFS_MASK, 32'h0, q);
    check(q, 32'h1 << mailbox_pkg::EV_ONE_WR);
    wb_xfer(1'b0, 8'h40, 32'h0, q);
    check(q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d1 = 18'($urandom);
      d2 = ~d1;
      f = 18'($urandom);
      ca_data <= 18'($urandom);
      pp.write_a(1'b1, d1);
      settle();
      check(full_one_n, 1'b0);
      check(irq, 1'b1);
      pp.write_a(1'b1, d2);
      settle();
      wb_xfer(1'b0, mailbox_pkg::OFS_MAIL_ONE, 32'h0, q);
      check(q, d1);
      pp.read_b(1'b1);
      settle();
      check(tx_data, d1);
      check(full_one_n, 1'b1);
      check(rd_ptr, 11'(i));
      wb_xfer(1'b1, mailbox_pkg::OFS_STATUS,
              32'h1 << mailbox_pkg::EV_ONE_WR, q);
      check(irq, 1'b0);
      pp.write_c(1'b1, d1);
      settle();
      check(full_two_n, 1'b0);
      pp.write_c(1'b1, d2);
      settle();
      pp.read_a(1'b1);
      settle();
      check(a_dout, d1);
      check(full_two_n, 1'b1);
      ab_data <= f;
      pp.read_b(1'b0);
      settle();
      check(tx_data, f);
    end
    check(rd_ptr, 11'h4);
    pp.write_c(1'b0, d1);
    settle();
    check(full_two_n, 1'b1);
    pp.write_a(1'b1, 18'h2aaaa);
    pp.write_c(1'b1, 18'h15555);
    // Select low on port A: FIFO traffic, mailboxes untouched
    pp.write_a(1'b0, d2);
    pp.read_a(1'b0);
    settle();
    check(wr_ptr, 11'h1);
    check(a_dout, ca_data);
    check({full_one_n, full_two_n}, 2'h0);
    wb_xfer(1'b0, mailbox_pkg::OFS_MAIL_ONE, 32'h0, q);
    check(q, 32'h2aaaa);
    pp.partial_reset(1'b0);
    settle();
    check({full_one_n, full_two_n}, 2'h2);
    pp.partial_reset(1'b1);
    settle();
    check(full_two_n, 1'b1);
    pp.write_a(1'b1, 18'h0f0f0);
    pp.write_c(1'b1, 18'h0a5a5);
    settle();
    check({full_one_n, full_two_n}, 2'h0);
    do_master_reset();
    complete_run();
  end
endmodule : mailbox_bypass_and_master_reset_tb_top
`default_nettype wire
